/* verilog/gifd_top.sv */
// Top of the external-interrupt flag and debug configuration block.
// Assumes one 100 MHz clock, a register master that never waits, and
// pins, strap and debugger levels arriving asynchronously.
`timescale 1ns/1ps
`default_nettype none
module gifd_top #(
  parameter int         FILT_CYCLES = 4,
  parameter logic [4:0] CH_A_PIN    = 5'h00,
  parameter logic [4:0] CH_B_PIN    = 5'h01
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  input  wire logic [23:0] pins_i,
  input  wire logic        boot_strap_pin_n_i,
  input  wire logic        debugger_forced_active_i,
  input  wire logic        serial_wire_enabled_i,
  input  wire logic        preserved_reserved_we_i,
  input  wire logic        preserved_reserved_i,
  input  wire logic        regulator_enable_i,
  input  wire logic        port_a_bit7_gpio_i,
  output logic             port_a_bit7_o,
  output logic             regulator_enable_pin_override_o,
  output logic             debug_override_allow_o,
  output logic [3:0]       ext_int_pending_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [26:0] async_in;
  logic [26:0] sync_out;
  logic [23:0] pins_s;
  logic        boot_n_s;
  logic        forced_s;
  logic        swen_s;

  assign async_in = {serial_wire_enabled_i, debugger_forced_active_i, boot_strap_pin_n_i, pins_i};

  gifd_sync #(.W(27)) u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (async_in),
    .q_o    (sync_out)
  );

  assign pins_s   = sync_out[23:0];
  assign boot_n_s = sync_out[24];
  assign forced_s = sync_out[25];
  assign swen_s   = sync_out[26];

  // ****************************************
  // Register state
  // ****************************************
  logic [3:0]  pend_q;
  logic [3:0]  stat_q;
  logic [3:0]  mask_q;
  logic [2:0]  mode_q [4];
  logic [3:0]  filt_q;
  logic [4:0]  sel_c_q;
  logic [4:0]  sel_d_q;
  logic        dbg_dis_q;
  logic        regen_q;
  logic        rsvd_q;
  logic        boot_q;
  logic        boot_done_q;
  logic [1:0]  boot_cnt_q;
  logic [3:0]  ev;
  logic [3:0]  chan_in;
  logic [31:0] rmux;
  logic        dbg_active;

  // ****************************************
  // Channel pin selection and trigger detection
  // ****************************************
  function automatic logic pick_pin(input logic [23:0] pins, input logic [4:0] sel);
    pick_pin = (sel < gifd_pkg::SEL_RSVD) ? pins[sel] : 1'b0;
  endfunction

  // A reserved selector feeds a constant low, so the channel only sees level-low triggers.
  always_comb begin
    chan_in[0]             = pick_pin(pins_s, CH_A_PIN);
    chan_in[1]             = pick_pin(pins_s, CH_B_PIN);
    chan_in[gifd_pkg::CH_C] = pick_pin(pins_s, sel_c_q);
    chan_in[gifd_pkg::CH_D] = pick_pin(pins_s, sel_d_q);
  end

  for (genvar i = 0; i < gifd_pkg::NUM_CH; i++) begin : g_ch
    gifd_trig #(.FILT_CYCLES(FILT_CYCLES)) u_trig (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .pin_i     (chan_in[i]),
      .mode_i    (mode_q[i]),
      .filt_en_i (filt_q[i]),
      .event_o   (ev[i])
    );
  end

  // ****************************************
  // Pending flags and interrupt status
  // ****************************************
  logic pend_wr;
  logic stat_rd;

  assign pend_wr = wr_i && gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_PEND);
  assign stat_rd = rd_i && gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_IRQ_STAT);

  // A trigger in the same cycle as the clear keeps its flag set.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= 4'h0;
    end else begin
      pend_q <= (pend_q & ~(pend_wr ? wdata_i[3:0] : 4'h0)) | ev;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_rd ? 4'h0 : stat_q) | ev;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= 4'h0;
    end else if (wr_i && gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_IRQ_MASK)) begin
      mask_q <= wdata_i[3:0];
    end
  end

  assign irq_o             = |(stat_q & mask_q);
  assign ext_int_pending_o = pend_q;

  // ****************************************
  // Channel configuration and pin selectors
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < gifd_pkg::NUM_CH; i++) begin
        mode_q[i] <= gifd_pkg::MODE_OFF;
      end
      filt_q <= 4'h0;
    end else begin
      for (int i = 0; i < gifd_pkg::NUM_CH; i++) begin
        if (wr_i && gifd_pkg::gifd_hit(addr_i,
            gifd_pkg::OFF_CFG_A + 32'(i) * gifd_pkg::CFG_STRIDE)) begin
          mode_q[i] <= wdata_i[gifd_pkg::CFG_MODE_LSB +: gifd_pkg::MODE_W];
          filt_q[i] <= wdata_i[gifd_pkg::CFG_FILT_BIT];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_c_q <= gifd_pkg::SEL_C_RST;
      sel_d_q <= gifd_pkg::SEL_D_RST;
    end else if (wr_i) begin
      if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_SEL_C)) begin
        sel_c_q <= wdata_i[gifd_pkg::SEL_W-1:0];
      end
      if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_SEL_D)) begin
        sel_d_q <= wdata_i[gifd_pkg::SEL_W-1:0];
      end
    end
  end

  // ****************************************
  // Debug configuration
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dbg_dis_q <= 1'b0;
      regen_q   <= gifd_pkg::REGEN_RST;
    end else if (wr_i && gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_DBGCFG)) begin
      dbg_dis_q <= wdata_i[gifd_pkg::DBG_DIS_BIT];
      regen_q   <= wdata_i[gifd_pkg::DBG_REGEN_BIT];
    end
  end

  // Hardware updates win, since software is expected to write back what it last read.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsvd_q <= 1'b0;
    end else if (preserved_reserved_we_i) begin
      rsvd_q <= preserved_reserved_i;
    end else if (wr_i && gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_DBGCFG)) begin
      rsvd_q <= wdata_i[gifd_pkg::DBG_RSVD_BIT];
    end
  end

  assign dbg_active = forced_s | swen_s;

  // An interface that is already up keeps its pins even after the disable bit is set.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      debug_override_allow_o <= 1'b1;
    end else begin
      debug_override_allow_o <= ~dbg_dis_q | dbg_active;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_a_bit7_o <= 1'b0;
    end else begin
      port_a_bit7_o <= regen_q ? regulator_enable_i : port_a_bit7_gpio_i;
    end
  end

  assign regulator_enable_pin_override_o = regen_q;

  // ****************************************
  // Boot strap capture
  // ****************************************
  // The strap is taken once the synchroniser has flushed its reset value.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_cnt_q  <= 2'h0;
      boot_done_q <= 1'b0;
      boot_q      <= 1'b0;
    end else if (!boot_done_q) begin
      if (boot_cnt_q == gifd_pkg::BOOT_CAP_CNT) begin
        boot_q      <= ~boot_n_s;
        boot_done_q <= 1'b1;
      end else begin
        boot_cnt_q <= boot_cnt_q + 2'h1;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    rmux = 32'h0000_0000;
    if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_PEND)) begin
      rmux[3:0] = pend_q;
    end
    if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_IRQ_STAT)) begin
      rmux[3:0] = stat_q;
    end
    if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_IRQ_MASK)) begin
      rmux[3:0] = mask_q;
    end
    for (int i = 0; i < gifd_pkg::NUM_CH; i++) begin
      if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_CFG_A + 32'(i) * gifd_pkg::CFG_STRIDE)) begin
        rmux[gifd_pkg::CFG_MODE_LSB +: gifd_pkg::MODE_W] = mode_q[i];
        rmux[gifd_pkg::CFG_FILT_BIT]                     = filt_q[i];
      end
    end
    if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_SEL_C)) begin
      rmux[gifd_pkg::SEL_W-1:0] = sel_c_q;
    end
    if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_SEL_D)) begin
      rmux[gifd_pkg::SEL_W-1:0] = sel_d_q;
    end
    if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_DBGCFG)) begin
      rmux[gifd_pkg::DBG_DIS_BIT]   = dbg_dis_q;
      rmux[gifd_pkg::DBG_REGEN_BIT] = regen_q;
      rmux[gifd_pkg::DBG_RSVD_BIT]  = rsvd_q;
    end
    if (gifd_pkg::gifd_hit(addr_i, gifd_pkg::OFF_DBGSTAT)) begin
      rmux[gifd_pkg::ST_BOOT_BIT]  = boot_q;
      rmux[gifd_pkg::ST_FORCE_BIT] = forced_s;
      rmux[gifd_pkg::ST_SWEN_BIT]  = swen_s;
    end
  end

  // Data stand for exactly the cycle after the read strobe, zero otherwise.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? rmux : 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_flag_sets_event: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ev != 4'h0) |=> ((pend_q & $past(ev)) == $past(ev)))
    else $error("Trigger event did not set its pending flag.");

  a_flag_w1c_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (pend_wr && ev == 4'h0) |=> (pend_q == ($past(pend_q) & ~$past(wdata_i[3:0]))))
    else $error("Pending flags wrong after a write-one-to-clear.");

  a_sel_reserved: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sel_c_q >= gifd_pkg::SEL_RSVD) |-> !chan_in[gifd_pkg::CH_C])
    else $error("Reserved selector drove channel C from a pin.");

  a_dbg_block: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (dbg_dis_q && !dbg_active) |=> !debug_override_allow_o)
    else $error("Debug override allowed while disabled and inactive.");

  a_regen_route: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    regen_q |=> (port_a_bit7_o == $past(regulator_enable_i)))
    else $error("Port A bit 7 not carrying the regulator enable.");

  a_boot_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (boot_done_q && $past(boot_done_q)) |-> $stable(boot_q))
    else $error("Latched boot strap changed after capture.");

  a_forced_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rd_i && addr_i == gifd_pkg::OFF_DBGSTAT) |=> (rdata_o[1] == $past(forced_s)))
    else $error("Forced-debug status bit read wrong.");

  a_swen_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rd_i && addr_i == gifd_pkg::OFF_DBGSTAT) |=> (rdata_o[0] == $past(swen_s)))
    else $error("Serial-wire status bit read wrong.");

  a_unused_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rd_i && addr_i == gifd_pkg::OFF_DBGSTAT) |=> (rdata_o[31:4] == 28'h0 && !rdata_o[2]))
    else $error("Unused status bits read nonzero.");

  a_sel_reserved_d: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sel_d_q >= gifd_pkg::SEL_RSVD) |-> !chan_in[gifd_pkg::CH_D])
    else $error("Reserved selector drove channel D from a pin.");

  a_dbg_permit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !dbg_dis_q |=> debug_override_allow_o)
    else $error("Debug override blocked although the disable bit is clear.");

  a_regen_bypass: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !regen_q |=> (port_a_bit7_o == $past(port_a_bit7_gpio_i)))
    else $error("Port A bit 7 not carrying its normal value.");

  a_boot_capture: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!boot_done_q && boot_cnt_q == gifd_pkg::BOOT_CAP_CNT) |=> (boot_q == !$past(boot_n_s)))
    else $error("Boot strap latched with the wrong sense.");

  a_status_ro: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_i && addr_i == gifd_pkg::OFF_DBGSTAT && boot_done_q) |=> $stable(boot_q))
    else $error("Write to the status register changed the boot bit.");

endmodule
`default_nettype wire

/* inc/gifd_pkg.sv */
// Constants for the external-interrupt flag and debug configuration block.
// Assumes a single 100 MHz system clock and a plain address/strobe register port.
// Functional notes
// - Four pending flags, channels A to D in bits 0 to 3, set by trigger.
// - Writing one clears a pending flag; writing zero leaves it alone.
// - Three-bit trigger code: off, rise, fall, both, high, low; 6 and 7 reserved.
// - Configuration bit 8 enables digital filtering before trigger detection.
// - Channels C and D choose their pin by 5-bit selector; 0x18 up reserved.
// - Disable bit 5 blocks debug pin override unless debug is already active.
// - Bit 4 routes regulator enable onto port A bit 7; set after reset.
// - Boot strap pin sampled at end of reset; status bit 3 is 1 if low.
// - Status bit 1 shows the debugger cable forcing debug active.
// - Status bit 0 shows the serial-wire debug interface enabled.

package gifd_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W       = 32;
  localparam int          DATA_W       = 32;
  localparam logic [31:0] OFF_PEND     = 32'h4000a814;
  localparam logic [31:0] OFF_CFG_A    = 32'h4000a860;
  localparam logic [31:0] CFG_STRIDE   = 32'h00000004;
  localparam logic [31:0] OFF_IRQ_STAT = 32'h4000a900;
  localparam logic [31:0] OFF_IRQ_MASK = 32'h4000a904;
  localparam logic [31:0] OFF_DBGCFG   = 32'h4000bc00;
  localparam logic [31:0] OFF_DBGSTAT  = 32'h4000bc04;
  localparam logic [31:0] OFF_SEL_C    = 32'h4000bc14;
  localparam logic [31:0] OFF_SEL_D    = 32'h4000bc18;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         NUM_CH        = 4;
  localparam int         NUM_PINS      = 24;
  localparam int         CFG_FILT_BIT  = 8;
  localparam int         CFG_MODE_LSB  = 5;
  localparam int         MODE_W        = 3;
  localparam int         SEL_W         = 5;
  localparam logic [4:0] SEL_RSVD      = 5'h18;
  localparam logic [4:0] SEL_C_RST     = 5'h0f;
  localparam logic [4:0] SEL_D_RST     = 5'h10;
  localparam int         DBG_DIS_BIT   = 5;
  localparam int         DBG_REGEN_BIT = 4;
  localparam int         DBG_RSVD_BIT  = 3;
  localparam logic       REGEN_RST     = 1'b1;
  localparam int         ST_BOOT_BIT   = 3;
  localparam int         ST_FORCE_BIT  = 1;
  localparam int         ST_SWEN_BIT   = 0;
  localparam int         CH_C          = 2;
  localparam int         CH_D          = 3;
  localparam logic [1:0] BOOT_CAP_CNT  = 2'h2;

  // ****************************************
  // Trigger codes
  // ****************************************
  localparam logic [2:0] MODE_OFF  = 3'h0;
  localparam logic [2:0] MODE_RISE = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_BOTH = 3'h3;
  localparam logic [2:0] MODE_HIGH = 3'h4;
  localparam logic [2:0] MODE_LOW  = 3'h5;

  function automatic logic gifd_hit(input logic [31:0] addr, input logic [31:0] off);
    gifd_hit = (addr == off);
  endfunction

endpackage

/* verilog/gifd_sync.sv */
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no word coherence is promised across bits.
`timescale 1ns/1ps
`default_nettype none
module gifd_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* verilog/gifd_trig.sv */
// One external interrupt channel: optional glitch filter and trigger detector.
// Assumes pin_i is already synchronised to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module gifd_trig #(
  parameter int FILT_CYCLES = 4
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       pin_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       filt_en_i,
  output logic            event_o
);
  logic       filt_q;
  logic [7:0] cnt_q;
  logic       prev_q;
  logic       sel;

  // The filtered level follows the pin only after it has differed for FILT_CYCLES cycles.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filt_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (pin_i == filt_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(FILT_CYCLES - 1)) begin
      filt_q <= pin_i;
      cnt_q  <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign sel = filt_en_i ? filt_q : pin_i;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q  <= 1'b0;
      event_o <= 1'b0;
    end else begin
      prev_q <= sel;
      case (mode_i)
        gifd_pkg::MODE_RISE: event_o <= sel & ~prev_q;
        gifd_pkg::MODE_FALL: event_o <= ~sel & prev_q;
        gifd_pkg::MODE_BOTH: event_o <= sel ^ prev_q;
        gifd_pkg::MODE_HIGH: event_o <= sel;
        gifd_pkg::MODE_LOW:  event_o <= ~sel;
        default:             event_o <= 1'b0;
      endcase
    end
  end

  a_mode_quiet: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (mode_i == gifd_pkg::MODE_OFF || mode_i > gifd_pkg::MODE_LOW) |=> !event_o)
    else $error("Event raised by an off or reserved trigger code.");

  a_filter_glitch: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (filt_en_i && $past(filt_en_i) && mode_i == gifd_pkg::MODE_RISE && $stable(mode_i)
     && $rose(pin_i)) |=> !event_o)
    else $error("Filtered channel reacted to a fresh pin edge at once.");
endmodule
`default_nettype wire

/* verification/gifd_tb.sv */
// Self-checking bench for the interrupt flag and debug configuration block.
// Assumes gifd_pkg and gifd_top are compiled first; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [23:0] pins_i = 24'h0;
  logic        boot_n = 1'b0;
  logic        forced = 1'b0;
  logic        swen = 1'b0;
  logic        rsv_we = 1'b0;
  logic        rsv_val = 1'b0;
  logic        reg_en = 1'b0;
  logic        gpio7 = 1'b0;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic        pa7;
  logic        regen_ovr;
  logic        allow;
  logic [3:0]  pend;
  logic [31:0] seed = 32'h0000a112;
  int          failures = 0;
  int          samples_checked = 0;

  always #5 mclk_i = ~mclk_i;

  // The filter is shortened so that a one-cycle glitch and a held level differ quickly.
  gifd_top #(.FILT_CYCLES(2), .CH_A_PIN(5'h00), .CH_B_PIN(5'h01)) u_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pins_i(pins_i),
    .boot_strap_pin_n_i(boot_n), .debugger_forced_active_i(forced),
    .serial_wire_enabled_i(swen), .preserved_reserved_we_i(rsv_we),
    .preserved_reserved_i(rsv_val), .regulator_enable_i(reg_en),
    .port_a_bit7_gpio_i(gpio7), .port_a_bit7_o(pa7),
    .regulator_enable_pin_override_o(regen_ovr), .debug_override_allow_o(allow),
    .ext_int_pending_o(pend));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic hit(input logic [2:0] m, input logic a, input logic b);
    case (m)
      3'h1: hit = !a && b;
      3'h2: hit = a && !b;
      3'h3: hit = a != b;
      3'h4: hit = a || b;
      3'h5: hit = !a || !b;
      default: hit = 1'b0;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    // The data stand until the next edge, so they are taken there before it updates them.
    @(posedge mclk_i);
    d = rdata_o;
  endtask

  task automatic finish_test();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    failures++;
    finish_test();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [31:0] r, d, v;
    int p;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    tick(4);
    chk(regen_ovr, 32'h1);
    rd(gifd_pkg::OFF_DBGCFG, d);
    chk(d, 32'h10);
    rd(gifd_pkg::OFF_PEND, d);
    chk(d, 32'h0);
    rd(gifd_pkg::OFF_SEL_C, d);
    chk(d, 32'h0f);
    rd(gifd_pkg::OFF_SEL_D, d);
    chk(d, 32'h10);
    rd(32'h4000bc08, d);
    chk(d, 32'h0);
    // Every trigger code, reserved ones too, against all four level pairs.
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 4; k++) begin
        wr(gifd_pkg::OFF_CFG_A, 32'h0);
        @(posedge mclk_i);
        pins_i[0] <= k[1];
        tick(8);
        wr(gifd_pkg::OFF_CFG_A, 32'(m) << gifd_pkg::CFG_MODE_LSB);
        wr(gifd_pkg::OFF_PEND, 32'hf);
        @(posedge mclk_i);
        pins_i[0] <= k[0];
        tick(8);
        rd(gifd_pkg::OFF_PEND, d);
        chk(d, {31'h0, hit(3'(m), k[1], k[0])});
      end
    end
    // A one-cycle glitch is swallowed by the filter but caught without it.
    v = gifd_pkg::OFF_CFG_A + gifd_pkg::CFG_STRIDE;
    wr(v, 32'h120);
    wr(gifd_pkg::OFF_PEND, 32'hf);
    @(posedge mclk_i);
    pins_i[1] <= 1'b1;
    @(posedge mclk_i);
    pins_i[1] <= 1'b0;
    tick(10);
    rd(gifd_pkg::OFF_PEND, d);
    chk(d, 32'h0);
    @(posedge mclk_i);
    pins_i[1] <= 1'b1;
    tick(12);
    rd(gifd_pkg::OFF_PEND, d);
    chk(d, 32'h2);
    pins_i[1] <= 1'b0;
    wr(v, 32'h20);
    tick(8);
    wr(gifd_pkg::OFF_PEND, 32'hf);
    pins_i[1] <= 1'b1;
    @(posedge mclk_i);
    pins_i[1] <= 1'b0;
    wr(gifd_pkg::OFF_CFG_A, 32'h60);
    pins_i[0] <= ~pins_i[0];
    tick(8);
    // Writing zeros keeps the flags; a one clears only its own flag.
    wr(gifd_pkg::OFF_PEND, 32'h0);
    rd(gifd_pkg::OFF_PEND, d);
    chk(d, 32'h3);
    wr(gifd_pkg::OFF_PEND, 32'h2);
    rd(gifd_pkg::OFF_PEND, d);
    chk(d, 32'h1);
    chk(pend, 32'h1);
    chk(irq_o, 32'h0);
    wr(gifd_pkg::OFF_IRQ_MASK, 32'h1);
    tick(1);
    chk(irq_o, 32'h1);
    rd(gifd_pkg::OFF_IRQ_STAT, d);
    chk(d, 32'h3);
    tick(1);
    chk(irq_o, 32'h0);
    rd(gifd_pkg::OFF_IRQ_STAT, d);
    chk(d, 32'h0);
    // Channel C follows a random selected pin; a reserved selector ignores rising pins.
    p = 2 + int'(rnd() % 22);
    wr(gifd_pkg::OFF_SEL_C, 32'(p));
    wr(gifd_pkg::OFF_CFG_A + 2 * gifd_pkg::CFG_STRIDE, 32'h20);
    wr(gifd_pkg::OFF_PEND, 32'hf);
    pins_i[p] <= 1'b1;
    tick(8);
    rd(gifd_pkg::OFF_PEND, d);
    chk(d, 32'h4);
    wr(gifd_pkg::OFF_SEL_C, 32'h18);
    pins_i <= 24'h0;
    tick(6);
    wr(gifd_pkg::OFF_PEND, 32'hf);
    pins_i <= 24'hffffff;
    tick(8);
    rd(gifd_pkg::OFF_PEND, d);
    chk(d, 32'h3);
    // Hardware loads the preserved bit; software then writes it back.
    @(posedge mclk_i);
    rsv_we  <= 1'b1;
    rsv_val <= 1'b1;
    @(posedge mclk_i);
    rsv_we <= 1'b0;
    rd(gifd_pkg::OFF_DBGCFG, d);
    chk(d[3], 32'h1);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      forced <= r[0];
      swen   <= r[1];
      reg_en <= r[2];
      gpio7  <= r[3];
      rd(gifd_pkg::OFF_DBGCFG, d);
      wr(gifd_pkg::OFF_DBGCFG, {r[31:6], r[5:4], d[3], r[2:0]});
      wr(gifd_pkg::OFF_DBGSTAT, rnd());
      tick(5);
      rd(gifd_pkg::OFF_DBGCFG, v);
      chk(v, {26'h0, r[5:4], d[3], 3'h0});
      rd(gifd_pkg::OFF_DBGSTAT, v);
      chk(v, {28'h0, 1'b1, 1'b0, r[0], r[1]});
      chk(allow, !r[5] || r[0] || r[1]);
      chk(regen_ovr, r[4]);
      chk(pa7, r[4] ? r[2] : r[3]);
    end
    // A second reset with the strap released must latch a clear boot bit.
    boot_n <= 1'b1;
    rstn_i <= 1'b0;
    tick(3);
    rstn_i <= 1'b1;
    chk(pend, 32'h0);
    chk(irq_o, 32'h0);
    tick(4);
    rd(gifd_pkg::OFF_DBGSTAT, v);
    chk(v, {30'h0, forced, swen});
    rd(gifd_pkg::OFF_DBGCFG, v);
    chk(v, 32'h10);
    finish_test();
  end
endmodule
`default_nettype wire
